// ===== reset_seq_pkg.sv
// constants and types for the chip reset input sequencer
// Behaviour
// - reset pin low holds core logic reset
// - latch boot strap on pin release
// - release internal reset after fixed clock count
// - pin-only reset leaves debug logic untouched
// - power-on detector asserts reset independently
// - reset output follows internal reset state
// - pull-up on unless disable bit set
// - high strap selects external boot unless secured
package reset_seq_pkg;
  localparam int unsigned RELEASE_COUNT   = 32;
  localparam int unsigned CNT_W           = 16;
  localparam logic [1:0]  SYNC_RESET_VAL  = 2'h0;
  localparam logic        STRAP_RESET_VAL = 1'h0;
  localparam logic        PUD_RESET_VAL   = 1'h0;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_COUNT   = 2'b01,
    ST_RUN     = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    BOOT_INTERNAL = 2'b00,
    BOOT_EXTERNAL = 2'b01
  } boot_mode_t;
endpackage : reset_seq_pkg

// ===== reset_req_if.sv
// synchronised reset request passed between sync stage and sequencer
interface reset_req_if;
  logic req_sync;
  modport src (output req_sync);
  modport dst (input  req_sync);
endinterface : reset_req_if

// ===== reset_req_sync.sv
// two-stage synchroniser for the combined reset request
module reset_req_sync (
  input  wire logic  clk,
  input  wire logic  por_n,
  input  wire logic  reset_pin_n,
  reset_req_if.src   out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;
  logic     arst_n;

  // either source forces the chain; release is clocked out
  assign arst_n = por_n & reset_pin_n;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = 1'h1;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= reset_seq_pkg::SYNC_RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // high means reset still requested
  assign out.req_sync = ~st_r.s2;
endmodule : reset_req_sync

// ===== reset_sequencer.sv
// chip reset sequencer: combine sources, delay release, latch boot strap
module reset_sequencer #(
  parameter int unsigned RELEASE_CYCLES = reset_seq_pkg::RELEASE_COUNT
) (
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  reset_pin_n,
  input  wire logic  test_reset_n,
  input  wire logic  boot_source_strap,
  input  wire logic  flash_secured,
  input  wire logic  pud_reset_bit_wr,
  input  wire logic  pud_reset_bit_val,
  output logic       core_reset_n,
  output logic       debug_reset_n,
  output logic       reset_state_out,
  output logic       pullup_enable,
  output logic       boot_external,
  output logic       strap_captured
);
  typedef struct packed {
    reset_seq_pkg::seq_state_t state;
    logic [reset_seq_pkg::CNT_W-1:0] cnt;
    logic                      strap;
    logic                      strap_vld;
    logic                      pud;
    logic                      rst_out;
  } seq_st_t;

  localparam logic [reset_seq_pkg::CNT_W-1:0] LAST_CNT =
    reset_seq_pkg::CNT_W'(RELEASE_CYCLES - 1);

  reset_req_if req_if ();
  seq_st_t     st_r;
  seq_st_t     st_nxt;

  // expiry decode shared by the counter and its check
  function automatic logic count_done(input seq_st_t s);
    return (s.state == reset_seq_pkg::ST_COUNT) && (s.cnt == LAST_CNT);
  endfunction : count_done

  // reset_n is the power-on detector output
  reset_req_sync u_sync (
    .clk         (clk),
    .por_n       (reset_n),
    .reset_pin_n (reset_pin_n),
    .out         (req_if.src)
  );

  always_comb begin
    st_nxt = st_r;
    if (req_if.req_sync) begin
      st_nxt.state   = reset_seq_pkg::ST_HOLD;
      st_nxt.cnt     = '0;
      st_nxt.rst_out = 1'h1;
    end else begin
      case (st_r.state)
        reset_seq_pkg::ST_HOLD: begin
          // first clean cycle after release: sample strap once
          st_nxt.strap     = boot_source_strap;
          st_nxt.strap_vld = 1'h1;
          st_nxt.state     = reset_seq_pkg::ST_COUNT;
          st_nxt.cnt       = '0;
        end
        reset_seq_pkg::ST_COUNT: begin
          if (count_done(st_r)) begin
            st_nxt.state   = reset_seq_pkg::ST_RUN;
            st_nxt.rst_out = 1'h0;
          end else begin
            st_nxt.cnt = st_r.cnt + 1'h1;
          end
        end
        reset_seq_pkg::ST_RUN: st_nxt.rst_out = 1'h0;
        default: st_nxt.state = reset_seq_pkg::ST_HOLD;
      endcase
    end
    // pull-up bit survives pin reset only if power is good; its own flop
    if (pud_reset_bit_wr && !st_r.rst_out) begin
      st_nxt.pud = pud_reset_bit_val;
    end
  end

  // whole state cleared only at power-on; pin path goes through sync
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.state     <= reset_seq_pkg::ST_HOLD;
      st_r.cnt       <= '0;
      st_r.strap     <= reset_seq_pkg::STRAP_RESET_VAL;
      st_r.strap_vld <= 1'h0;
      st_r.pud       <= reset_seq_pkg::PUD_RESET_VAL;
      st_r.rst_out   <= 1'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign core_reset_n    = ~st_r.rst_out;
  assign reset_state_out = st_r.rst_out;
  // debug logic follows only the test reset, not the chip pin
  assign debug_reset_n   = test_reset_n;
  assign pullup_enable   = ~st_r.pud;
  assign boot_external   = st_r.strap & ~flash_secured;
  assign strap_captured  = st_r.strap_vld;

  property p_hold_in_reset;
    @(posedge clk) disable iff (!reset_n)
      req_if.req_sync |=> reset_state_out;
  endproperty
  a_hold_in_reset: assert property (p_hold_in_reset)
    else $error("reset output low during request");

  property p_release_delay;
    @(posedge clk) disable iff (!reset_n)
      $fell(req_if.req_sync) |-> reset_state_out[*2];
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("reset released too early");

  property p_out_mirror;
    @(posedge clk) disable iff (!reset_n)
      reset_state_out == ~core_reset_n;
  endproperty
  a_out_mirror: assert property (p_out_mirror)
    else $error("reset output differs from internal reset");

  property p_strap;
    @(posedge clk) disable iff (!reset_n)
      (!req_if.req_sync && st_r.state == reset_seq_pkg::ST_HOLD)
        |=> st_r.strap == $past(boot_source_strap);
  endproperty
  a_strap: assert property (p_strap)
    else $error("boot strap not captured at release");

  property p_boot;
    @(posedge clk) disable iff (!reset_n)
      flash_secured |-> !boot_external;
  endproperty
  a_boot: assert property (p_boot)
    else $error("external boot while secured");

  property p_pullup;
    @(posedge clk) disable iff (!reset_n)
      (pud_reset_bit_wr && !reset_state_out)
        |=> pullup_enable == !$past(pud_reset_bit_val);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up does not follow disable bit");

  property p_debug;
    @(posedge clk) disable iff (!reset_n)
      debug_reset_n == test_reset_n;
  endproperty
  a_debug: assert property (p_debug)
    else $error("debug reset by chip pin");

  property p_sync_lat;
    @(posedge clk) disable iff (!reset_n)
      $rose(reset_pin_n) |-> ##[1:3] !req_if.req_sync;
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("synchroniser latency wrong");

  property p_end_hold;
    @(posedge clk) disable iff (!reset_n)
      (count_done(st_r) && !req_if.req_sync) |=> !reset_state_out;
  endproperty
  a_end_hold: assert property (p_end_hold)
    else $error("reset not released at count expiry");

  // pin low reaches the output at the next edge, ahead of the sync
  property p_pin_hold;
    @(posedge clk) disable iff (!reset_n)
      !reset_pin_n |=> reset_state_out;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("reset output low while pin held");

  // a new request always restarts the delay from zero
  property p_cnt_reset;
    @(posedge clk) disable iff (!reset_n)
      req_if.req_sync |=> (st_r.cnt == '0);
  endproperty
  a_cnt_reset: assert property (p_cnt_reset)
    else $error("release counter not cleared by request");

  // strap frozen outside the capture cycle; later moves are ignored
  property p_strap_keep;
    @(posedge clk) disable iff (!reset_n)
      (st_r.state != reset_seq_pkg::ST_HOLD) |=> $stable(st_r.strap);
  endproperty
  a_strap_keep: assert property (p_strap_keep)
    else $error("boot strap changed outside capture");

  // only power-on clears the capture flag
  property p_strap_vld;
    @(posedge clk) disable iff (!reset_n)
      strap_captured |=> strap_captured;
  endproperty
  a_strap_vld: assert property (p_strap_vld)
    else $error("strap flag dropped without power-on");

  // writes during reset are lost; software must repeat them afterwards
  property p_pud_refused;
    @(posedge clk) disable iff (!reset_n)
      (pud_reset_bit_wr && reset_state_out) |=> $stable(pullup_enable);
  endproperty
  a_pud_refused: assert property (p_pud_refused)
    else $error("pull-up changed by write during reset");

  // once running, only a fresh request may bring reset back
  property p_run_stays;
    @(posedge clk) disable iff (!reset_n)
      (st_r.state == reset_seq_pkg::ST_RUN && !req_if.req_sync)
        |=> !reset_state_out;
  endproperty
  a_run_stays: assert property (p_run_stays)
    else $error("reset reasserted without a request");

  // open part with high strap must boot from outside
  property p_boot_open;
    @(posedge clk) disable iff (!reset_n)
      (st_r.strap && !flash_secured) |-> boot_external;
  endproperty
  a_boot_open: assert property (p_boot_open)
    else $error("high strap did not select external boot");

  // scenario coverage
  c_release: cover property (@(posedge clk) $fell(reset_state_out));
  c_pin_reset: cover property (@(posedge clk) $rose(reset_state_out));
  c_ext_boot: cover property (@(posedge clk) $rose(boot_external));
  c_pud: cover property (@(posedge clk) $fell(pullup_enable));
endmodule : reset_sequencer

// ===== board_reset_model.sv
// board side: reset pin, test reset and boot strap
module board_reset_model (
  input  wire logic clk,
  output logic      reset_pin_n,
  output logic      test_reset_n,
  output logic      boot_source_strap
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reset_pin_n = 1'h1;
    test_reset_n = 1'h1;
    boot_source_strap = 1'h0;
  end
  // strap is a tied level, so it stays put after release
  task automatic press(input logic full, input logic strap);
    @(negedge clk);
    reset_pin_n = 1'h0;
    test_reset_n = ~full;
    boot_source_strap = strap;
  endtask : press
  task automatic let_go();
    @(negedge clk);
    reset_pin_n = 1'h1;
    test_reset_n = 1'h1;
  endtask : let_go
endmodule : board_reset_model

// ===== testbench.sv
// self-checking bench for the chip reset sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RC = 4;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic flash_secured = 1'h0;
  logic pud_reset_bit_wr = 1'h1;
  logic pud_reset_bit_val = 1'h1;
  logic reset_pin_n, test_reset_n, boot_source_strap, core_reset_n;
  logic debug_reset_n, reset_state_out, pullup_enable, boot_external;
  logic strap_captured;
  int   num_errors = 0;
  int   num_checks = 0;
  always #20 clk = ~clk;
  board_reset_model board_reset_model_i (.clk(clk),
    .reset_pin_n(reset_pin_n), .test_reset_n(test_reset_n),
    .boot_source_strap(boot_source_strap));
  reset_sequencer #(.RELEASE_CYCLES(RC)) reset_sequencer_i (.clk(clk),
    .reset_n(reset_n), .reset_pin_n(reset_pin_n),
    .test_reset_n(test_reset_n), .boot_source_strap(boot_source_strap),
    .flash_secured(flash_secured), .pud_reset_bit_wr(pud_reset_bit_wr),
    .pud_reset_bit_val(pud_reset_bit_val), .core_reset_n(core_reset_n),
    .debug_reset_n(debug_reset_n), .reset_state_out(reset_state_out),
    .pullup_enable(pullup_enable), .boot_external(boot_external),
    .strap_captured(strap_captured));
  task automatic check(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // counts edges from release; a hang ends the run here
  task automatic wait_release();
    int n;
    n = 0;
    while (reset_state_out !== 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    num_checks++;
    if (n != RC + 3) begin
      num_errors++;
      $display("MISMATCH release_edges expected %0d seen %0d", RC + 3, n);
    end
    if (n == 100) begin
      wrap_up();
    end
    check("core_reset_n", 1'h1, core_reset_n);
  endtask : wait_release
  task automatic t_power_on();
    repeat (16) @(negedge clk);
    check("reset_state_out", 1'h1, reset_state_out);
    check("core_reset_n", 1'h0, core_reset_n);
    check("strap_captured", 1'h0, strap_captured);
    check("pullup_enable", 1'h1, pullup_enable);
    pud_reset_bit_wr = 1'h0;
    reset_n = 1'h1;
    wait_release();
    check("pullup_enable", 1'h1, pullup_enable);
    check("strap_captured", 1'h1, strap_captured);
    check("boot_external", 1'h0, boot_external);
  endtask : t_power_on
  task automatic t_pud();
    @(negedge clk);
    pud_reset_bit_wr = 1'h1;
    @(negedge clk);
    pud_reset_bit_wr = 1'h0;
    check("pullup_enable", 1'h0, pullup_enable);
  endtask : t_pud
  task automatic t_pin(input logic full, input logic strap, input logic sec);
    flash_secured = sec;
    board_reset_model_i.press(full, strap);
    @(negedge clk);
    // write while reset is up must be dropped
    pud_reset_bit_val = 1'h0;
    pud_reset_bit_wr = 1'h1;
    @(negedge clk);
    pud_reset_bit_wr = 1'h0;
    pud_reset_bit_val = 1'h1;
    @(negedge clk);
    check("pullup_enable", 1'h0, pullup_enable);
    check("reset_state_out", 1'h1, reset_state_out);
    check("core_reset_n", 1'h0, core_reset_n);
    check("debug_reset_n", ~full, debug_reset_n);
    board_reset_model_i.let_go();
    wait_release();
    check("boot_external", strap & ~sec, boot_external);
    check("strap_captured", 1'h1, strap_captured);
    check("pullup_enable", 1'h0, pullup_enable);
  endtask : t_pin
  initial begin
    t_power_on();
    t_pud();
    t_pin(1'h0, 1'h1, 1'h0);
    t_pin(1'h1, 1'h0, 1'h0);
    t_pin(1'h0, 1'h1, 1'h1);
    wrap_up();
  end
endmodule : testbench
